// File: src/power_mode_pkg.sv
package power_mode_pkg;

    // ****************************************
    // mode encoding, one-hot
    // ****************************************
    typedef enum logic [5:0] {
        ST_RUN       = 6'h01,
        ST_WAIT      = 6'h02,
        ST_STOP      = 6'h04,
        ST_VLP_RUN   = 6'h08,
        ST_VLP_WAIT  = 6'h10,
        ST_VLP_STOP  = 6'h20
    } power_state_e;

    // ****************************************
    // reported mode codes
    // ****************************************
    localparam logic [2:0] MODE_RUN = 3'h0;
    localparam logic [2:0] MODE_WAIT = 3'h1;
    localparam logic [2:0] MODE_STOP = 3'h2;
    localparam logic [2:0] MODE_VLP_RUN = 3'h4;
    localparam logic [2:0] MODE_VLP_WAIT = 3'h5;
    localparam logic [2:0] MODE_VLP_STOP = 3'h6;

    // ****************************************
    // clock limits in very-low-power run, in kHz
    // ****************************************
    localparam int VLP_CORE_CLOCK_KHZ = 4000;
    localparam int VLP_BUS_CLOCK_MAX_KHZ = 800;
    localparam int VLP_FLASH_ACCESS_KHZ = 1000;

endpackage

// File: src/chip_power_mode_controller.sv
module chip_power_mode_controller (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wfi_req_i,
    input wire logic deep_sleep_i,
    input wire logic enter_vlp_req_i,
    input wire logic exit_vlp_req_i,
    input wire logic irq_pending_i,
    input wire logic async_wake_i,
    input wire logic timer_stop_en_i,
    input wire logic timer_clk_src_en_i,
    input wire logic uart_stop_en_i,
    input wire logic uart_clk_src_en_i,
    output logic [2:0] mode_o,
    output logic core_clk_en_o,
    output logic bus_clk_en_o,
    output logic periph_clk_en_o,
    output logic timer_clk_en_o,
    output logic uart_clk_en_o,
    output logic regulator_full_o,
    output logic flash_slow_mode_o,
    output logic low_voltage_detect_en_o,
    output logic irq_ctrl_en_o,
    output logic async_wake_en_o,
    output logic io_hold_o
);

    // ****************************************
    // input synchronisers
    // ****************************************
    // interrupt and wake levels arrive from other clock domains
    logic [1:0] wake_meta;
    logic [1:0] wake_sync;
    logic async_wake_s;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wake_meta <= 2'h0;
            wake_sync <= 2'h0;
        end else begin
            wake_meta <= {async_wake_i, irq_pending_i};
            wake_sync <= wake_meta;
        end
    end

    wire irq_s = wake_sync[0];
    assign async_wake_s = wake_sync[1];

    // ****************************************
    // mode sequencer
    // ****************************************
    power_mode_pkg::power_state_e state;
    power_mode_pkg::power_state_e next_state;

    // deep-sleep counts only in the cycle a wfi is taken
    // wait or stop select
    wire go_stop = deep_sleep_i;
    wire wake_any = irq_s | async_wake_s;

    always_comb begin
        next_state = state;
        case (state)
            power_mode_pkg::ST_RUN: begin
                // wfi wins over a vlp request in the same cycle
                // wfi sole entry
                if (wfi_req_i && go_stop) begin
                    next_state = power_mode_pkg::ST_STOP;
                end else if (wfi_req_i) begin
                    next_state = power_mode_pkg::ST_WAIT;
                end else if (enter_vlp_req_i) begin
                    next_state = power_mode_pkg::ST_VLP_RUN;
                end
            end
            power_mode_pkg::ST_WAIT: begin
                if (irq_s) begin
                    next_state = power_mode_pkg::ST_RUN;
                end
            end
            power_mode_pkg::ST_STOP: begin
                if (wake_any) begin
                    next_state = power_mode_pkg::ST_RUN;
                end
            end
            power_mode_pkg::ST_VLP_RUN: begin
                if (wfi_req_i && go_stop) begin
                    next_state = power_mode_pkg::ST_VLP_STOP;
                end else if (wfi_req_i) begin
                    next_state = power_mode_pkg::ST_VLP_WAIT;
                end else if (exit_vlp_req_i) begin
                    next_state = power_mode_pkg::ST_RUN;
                end
            end
            power_mode_pkg::ST_VLP_WAIT: begin
                if (irq_s) begin
                    next_state = power_mode_pkg::ST_VLP_RUN;
                end
            end
            // a stop returns to the run mode it was entered from
            // async wake to vlp run
            power_mode_pkg::ST_VLP_STOP: begin
                if (wake_any) begin
                    next_state = power_mode_pkg::ST_VLP_RUN;
                end
            end
            default: begin
                next_state = power_mode_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= power_mode_pkg::ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // mode decode
    // ****************************************
    wire in_run = (state == power_mode_pkg::ST_RUN);
    wire in_wait = (state == power_mode_pkg::ST_WAIT);
    wire in_stop = (state == power_mode_pkg::ST_STOP);
    wire in_vrun = (state == power_mode_pkg::ST_VLP_RUN);
    wire in_vwait = (state == power_mode_pkg::ST_VLP_WAIT);
    wire in_vstop = (state == power_mode_pkg::ST_VLP_STOP);
    // async wake input is heard only in the stop modes
    wire any_stop = in_stop | in_vstop;
    wire any_vlp = in_vrun | in_vwait | in_vstop;
    wire core_on = in_run | in_vrun;
    wire timer_keep = timer_stop_en_i & timer_clk_src_en_i;
    wire uart_keep = uart_stop_en_i & uart_clk_src_en_i;

    logic [2:0] next_mode;
    assign next_mode = in_wait ? power_mode_pkg::MODE_WAIT :
                       in_stop ? power_mode_pkg::MODE_STOP :
                       in_vrun ? power_mode_pkg::MODE_VLP_RUN :
                       in_vwait ? power_mode_pkg::MODE_VLP_WAIT :
                       in_vstop ? power_mode_pkg::MODE_VLP_STOP :
                       power_mode_pkg::MODE_RUN;

    // ****************************************
    // next output values
    // ****************************************
    // core sleeps in wait
    wire next_core_clk_en = core_on;
    wire next_bus_clk_en = ~any_stop;
    wire next_periph_clk_en = ~any_stop;

    wire next_timer_clk_en = ~any_stop | (in_vstop & timer_keep);
    wire next_uart_clk_en = ~any_stop | (in_vstop & uart_keep);

    wire next_regulator_full = ~any_vlp;
    wire next_flash_slow_mode = any_vlp;
    wire next_low_voltage_detect_en = ~any_vlp;

    wire next_irq_ctrl_en = ~any_stop;
    wire next_async_wake_en = any_stop;
    wire next_io_hold = 1'b1;

    // ****************************************
    // registered controls
    // ****************************************
    // registered so that no enable glitches on a mode change
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_o <= power_mode_pkg::MODE_RUN;
            core_clk_en_o <= 1'b1;
            bus_clk_en_o <= 1'b1;
            periph_clk_en_o <= 1'b1;
            timer_clk_en_o <= 1'b1;
            uart_clk_en_o <= 1'b1;
            regulator_full_o <= 1'b1;
            flash_slow_mode_o <= 1'b0;
            low_voltage_detect_en_o <= 1'b1;
            irq_ctrl_en_o <= 1'b1;
            async_wake_en_o <= 1'b0;
            io_hold_o <= 1'b1;
        end else begin
            mode_o <= next_mode;
            core_clk_en_o <= next_core_clk_en;
            bus_clk_en_o <= next_bus_clk_en;
            periph_clk_en_o <= next_periph_clk_en;
            timer_clk_en_o <= next_timer_clk_en;
            uart_clk_en_o <= next_uart_clk_en;
            regulator_full_o <= next_regulator_full;
            flash_slow_mode_o <= next_flash_slow_mode;
            low_voltage_detect_en_o <= next_low_voltage_detect_en;
            irq_ctrl_en_o <= next_irq_ctrl_en;
            async_wake_en_o <= next_async_wake_en;
            io_hold_o <= next_io_hold;
        end
    end

endmodule

// File: tb/chip_power_mode_asserts.sv
module chip_power_mode_asserts (
    input wire logic clk_i, rst_i, wfi_req_i, irq_pending_i, timer_stop_en_i, timer_clk_src_en_i,
    input wire logic [2:0] mode_o,
    input wire logic core_clk_en_o, periph_clk_en_o, regulator_full_o, flash_slow_mode_o,
    input wire logic low_voltage_detect_en_o, irq_ctrl_en_o, async_wake_en_o, timer_clk_en_o, io_hold_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_reset_run: assert property ($past(rst_i) |-> mode_o == 3'h0 && regulator_full_o)
        else $error("not in run after reset");
    a_wfi_entry: assert property ($past(mode_o) == 3'h0 && mode_o inside {1, 2} |->
        $past(wfi_req_i, 2)) else $error("sleep entered without wfi");
    a_wait_clocks: assert property (mode_o == 3'h1 |->
        !core_clk_en_o && periph_clk_en_o && irq_ctrl_en_o) else $error("wait clocks wrong");
    a_stop_gated: assert property (mode_o == 3'h2 |->
        !periph_clk_en_o && !irq_ctrl_en_o && low_voltage_detect_en_o && async_wake_en_o) else $error("stop not gated");
    a_vlp_wake: assert property (mode_o == 3'h6 && $rose(irq_pending_i) |-> ##[2:5] mode_o == 3'h4)
        else $error("no wake from vlp stop");
    a_vlp_run: assert property (mode_o == 3'h4 |->
        flash_slow_mode_o && !low_voltage_detect_en_o && !regulator_full_o) else $error("vlp run setup wrong");
    a_vlp_wait: assert property (mode_o == 3'h5 |->
        !core_clk_en_o && irq_ctrl_en_o && flash_slow_mode_o) else $error("vlp wait setup wrong");
    a_vlp_stop: assert property (mode_o == 3'h6 && $past(mode_o) == 3'h6 |->
        !periph_clk_en_o && !low_voltage_detect_en_o && timer_clk_en_o == $past(timer_stop_en_i && timer_clk_src_en_i))
        else $error("vlp stop setup wrong");
    a_io_held: assert property (io_hold_o)
        else $error("pins not held");
endmodule
bind chip_power_mode_controller chip_power_mode_asserts chip_power_mode_asserts_i (.*);

// File: tb/core_sleep_model.sv
module core_sleep_model (
    input wire logic clk_i,
    output logic wfi_req_o = 1'b0,
    output logic deep_sleep_o = 1'b0,
    output logic irq_pending_o = 1'b0,
    output logic async_wake_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic sleep(input logic deep);
        @(posedge clk_i);
        wfi_req_o <= 1'b1;
        deep_sleep_o <= deep;
        @(posedge clk_i);
        wfi_req_o <= 1'b0;
    endtask
    task automatic wake(input logic via_async, input logic level);
        @(posedge clk_i);
        if (via_async) async_wake_o <= level;
        else irq_pending_o <= level;
    endtask
endmodule

// File: tb/chip_power_mode_controller_bench.sv
module chip_power_mode_controller_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0, rst_i = 1'b1, enter_vlp_req_i = 1'b0, exit_vlp_req_i = 1'b0;
    logic timer_stop_en_i = 1'b1, timer_clk_src_en_i = 1'b1, uart_stop_en_i = 1'b1, uart_clk_src_en_i = 1'b0;
    logic wfi_req_i, deep_sleep_i, irq_pending_i, async_wake_i, core_clk_en_o, bus_clk_en_o, periph_clk_en_o;
    logic timer_clk_en_o, uart_clk_en_o, regulator_full_o, flash_slow_mode_o, low_voltage_detect_en_o, irq_ctrl_en_o;
    logic async_wake_en_o, io_hold_o;
    logic [2:0] mode_o;
    wire logic [10:0] snap = {mode_o, core_clk_en_o, bus_clk_en_o, periph_clk_en_o, regulator_full_o,
        flash_slow_mode_o, low_voltage_detect_en_o, irq_ctrl_en_o, async_wake_en_o};
    localparam logic [10:0] S_RUN = 11'h0F6, S_WAIT = 11'h176, S_STOP = 11'h215;
    localparam logic [10:0] S_VRUN = 11'h4EA, S_VWAIT = 11'h56A, S_VSTOP = 11'h609;
    int n_fail = 0;
    int tests_run = 0;
    always #50 clk_i = ~clk_i;
    core_sleep_model core_sleep_model_i (.clk_i(clk_i), .wfi_req_o(wfi_req_i), .deep_sleep_o(deep_sleep_i),
        .irq_pending_o(irq_pending_i), .async_wake_o(async_wake_i));
    chip_power_mode_controller chip_power_mode_controller_i (.*);
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t state %h expected %h", $time, got, exp);
        end
    endtask
    // bounded wait for the mode, then the whole state word
    task automatic expect_state(input logic [10:0] exp);
        repeat (12) if (mode_o !== exp[10:8]) @(negedge clk_i);
        chk(snap, exp);
        if (mode_o !== exp[10:8]) report_and_stop();
    endtask
    task automatic sleep_and_wake(input logic deep, input logic via_async, input logic [10:0] st, back);
        core_sleep_model_i.sleep(deep);
        expect_state(st);
        core_sleep_model_i.wake(via_async, 1'b1);
        expect_state(back);
        core_sleep_model_i.wake(via_async, 1'b0);
        repeat (3) @(posedge clk_i);
    endtask
    task automatic pulse(input logic to_vlp);
        @(posedge clk_i);
        enter_vlp_req_i <= to_vlp;
        exit_vlp_req_i <= !to_vlp;
        @(posedge clk_i);
        enter_vlp_req_i <= 1'b0;
        exit_vlp_req_i <= 1'b0;
    endtask
    task automatic vlp_modes;
        pulse(1'b1);
        expect_state(S_VRUN);
        sleep_and_wake(1'b0, 1'b0, S_VWAIT, S_VRUN);
        core_sleep_model_i.sleep(1'b1);
        expect_state(S_VSTOP);
        chk({9'h000, timer_clk_en_o, uart_clk_en_o}, 11'h002);
        core_sleep_model_i.wake(1'b0, 1'b1);
        expect_state(S_VRUN);
        core_sleep_model_i.wake(1'b0, 1'b0);
        pulse(1'b0);
        expect_state(S_RUN);
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk(snap, S_RUN);
        chk({10'h000, io_hold_o}, 11'h001);
        sleep_and_wake(1'b0, 1'b0, S_WAIT, S_RUN);
        sleep_and_wake(1'b1, 1'b1, S_STOP, S_RUN);
        vlp_modes();
        report_and_stop();
    end
endmodule
